/* File: pmw_pkg.sv */
// Package with constants, types and register map of the power mode, wake-up and watchdog block
// Function
// [RULE1] Slow RC runs in sleep unless configured off
// [RULE2] Crystal runs regardless of low-power select
// [RULE3] Slow select only valid in RC+crystal config
// [RULE4] Crystal always runs in RC+crystal config
// [RULE5] Halt stops fast clock, independent of select
// [RULE6] Sleep halts execution, keeps state unchanged
// [RULE7] Sleep clears watchdog; stops on system clock
// [RULE8] Halt sets power-down, clears expired flag
// [RULE9] Wake on reset, port fall, interrupt, overflow
// [RULE10] Reset wake full; watchdog wake sets expired
// [RULE11] Power-down flag cleared by power-up, clear
// [RULE12] Masked port A falling edges wake device
// [RULE13] Disabled interrupt wake resumes, stays pending
// [RULE14] Pending request before sleep blocks its wake
// [RULE15] Wake delays: reset plus 128, else 2/128
// [RULE16] Overflow resets; disabled watchdog ignores instructions
// [RULE17] Watchdog off only when config off and key 1010
// [RULE18] Enable key powers up as 1010
// [RULE19] Watchdog clock: crystal, system/4, or slow RC
// [RULE20] Scale bits 2:0 select prescale, all ones max
// [RULE21] Low-power select resets to quick start
// [RULE22] Period 2^8 to 2^15 clocks, resets 111
// [RULE23] Glitch-free switch between fast and slow clocks
package pmw_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [11:0] ADDR_CLOCK_CTRL = 12'h000; // Clock control register
  localparam logic [11:0] ADDR_WDT_CTRL = 12'h004; // Watchdog control register
  localparam logic [11:0] ADDR_WDT_SCALE = 12'h008; // Watchdog scale register
  localparam logic [11:0] ADDR_WAKE_MASK = 12'h00c; // Port A wake mask
  localparam logic [11:0] ADDR_STATUS = 12'h010; // Status flags and mode
  localparam logic [11:0] ADDR_COMMAND = 12'h014; // Instruction strobes

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int CC_LOWPWR_BIT = 0; // Crystal low-power select
  localparam int CC_SLOW_BIT = 1; // Slow clock select
  localparam int CMD_HALT_BIT = 0; // Halt instruction
  localparam int CMD_CLRWDT_BIT = 1; // Watchdog clear instruction
  localparam int ST_PDF_BIT = 0; // Power-down flag
  localparam int ST_TO_BIT = 1; // Watchdog expired flag
  localparam logic [3:0] KEY_DISABLE = 4'ha; // Key value that keeps watchdog off
  localparam logic [3:0] KEY_ENABLE = 4'h5; // Recommended enable key
  localparam logic [2:0] TSEL_RESET = 3'h7; // Time-out select reset value
  localparam logic [7:0] WAKE_MASK_RESET = 8'h00; // No pin wakes after reset
  localparam int WDT_BASE_LOG = 8; // Shortest period is 2^8 watchdog clocks

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10; // System clock period
  localparam int RESET_DELAY_MS = 50; // Typical reset delay
  localparam int RESET_DELAY_CYC = RESET_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [7:0] SHORT_STARTUP_CYC = 8'h02; // Startup with RC oscillators
  localparam logic [7:0] LONG_STARTUP_CYC = 8'h80; // Startup with crystal
  localparam logic [1:0] SYNC_DIV4 = 2'h3; // Divide-by-4 terminal count

  // ------------------------------------------------------------------
  // Configuration encodings
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    PMW_OSC_HXT = 3'h0, PMW_OSC_ERC = 3'h1, PMW_OSC_FAST_INTERNAL_OSC = 3'h2, PMW_OSC_FAST_INTERNAL_OSC_LXT = 3'h3
  } pmw_osc_cfg_t;

  typedef enum logic [1:0] {
    PMW_WCK_LXT = 2'h0, PMW_WCK_SYS4 = 2'h1, PMW_WCK_SLOW_INTERNAL_OSC = 2'h2
  } pmw_wdt_clk_t;

  // Configuration options bundled together
  typedef struct packed {
    logic [2:0] osc; // Oscillator configuration
    logic [1:0] wdt_clk; // Watchdog clock source
    logic wdt_on; // Watchdog enabled by configuration
    logic slow_internal_osc_on; // Slow RC enabled by configuration
  } pmw_cfg_t;

  // Oscillator enables and clock selection presented to the analog side
  typedef struct packed {
    logic fast_osc_en; // Fast oscillator enable
    logic slow_crystal_en; // Slow crystal enable
    logic slow_rc_en; // Slow RC enable
    logic crystal_low_power; // Crystal low-power mode
    logic sys_clk_slow; // System clock from slow crystal
  } pmw_osc_ctl_t;

  // States of the mode sequencer, one-hot
  typedef enum logic [3:0] {
    PMW_ST_RUN = 4'h1, PMW_ST_SLEEP = 4'h2, PMW_ST_RESET_DLY = 4'h4, PMW_ST_START_DLY = 4'h8
  } pmw_state_t;

endpackage

/* File: pmw_top.sv */
// Power mode controller with wake-up logic and watchdog
`timescale 1ns/100ps
module pmw_top #(
  parameter int RESET_DELAY_CYCLES = pmw_pkg::RESET_DELAY_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pmw_pkg::pmw_cfg_t cfg,
  input wire logic ext_reset_n,
  input wire logic [7:0] port_a_pins,
  input wire logic slow_tick,
  input wire logic int_request,
  input wire logic int_enabled,
  input wire logic stack_full,
  input wire logic int_pending_before,
  output pmw_pkg::pmw_osc_ctl_t osc_ctl,
  output logic core_run,
  output logic core_hold,
  output logic full_reset,
  output logic pc_sp_reset,
  output logic int_service
);

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------
  // True when the oscillator option is fast RC plus slow crystal
  function automatic logic is_rc_xtal(input logic [2:0] osc);
    is_rc_xtal = (osc == pmw_pkg::PMW_OSC_FAST_INTERNAL_OSC_LXT);
  endfunction

  // True when the oscillator option is external RC or fast internal RC alone
  function automatic logic is_rc(input logic [2:0] osc);
    is_rc = (osc == pmw_pkg::PMW_OSC_ERC) || (osc == pmw_pkg::PMW_OSC_FAST_INTERNAL_OSC);
  endfunction

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [7:0] pa_s1_r, pa_s2_r, pa_prev_r; // Port A sync and history
  logic [2:0] rst_s_r; // External reset sync and history
  logic [2:0] tick_s_r; // Slow clock tick sync and history

  // Two flops on every pin, a third stage for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_s1_r <= 8'hff;
      pa_s2_r <= 8'hff;
      pa_prev_r <= 8'hff;
      rst_s_r <= 3'h7;
      tick_s_r <= 3'h0;
    end else begin
      pa_s1_r <= port_a_pins;
      pa_s2_r <= pa_s1_r;
      pa_prev_r <= pa_s2_r;
      rst_s_r <= {rst_s_r[1:0], ext_reset_n};
      tick_s_r <= {tick_s_r[1:0], slow_tick};
    end
  end

  logic ext_rst_lvl; // Synchronised external reset, active high
  logic slow_edge; // One pulse per slow oscillator cycle
  assign ext_rst_lvl = !rst_s_r[1];
  assign slow_edge = tick_s_r[1] && !tick_s_r[2];

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic lowpwr_r; // Crystal low-power select
  logic slow_sel_r; // Slow clock select
  logic [3:0] key_r; // Watchdog enable key
  logic [2:0] tsel_r; // Time-out select
  logic [7:0] wake_mask_r; // Port A wake mask
  logic pdf_r; // Power-down flag
  logic to_r; // Watchdog expired flag
  pmw_pkg::pmw_state_t state_r; // Mode sequencer state

  logic wr_en, rd_en; // Access phase strobes
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  logic halt_cmd, clr_cmd; // Instruction strobes
  logic wdt_active; // Watchdog function on
  assign halt_cmd = wr_en && (paddr == pmw_pkg::ADDR_COMMAND) && pwdata[pmw_pkg::CMD_HALT_BIT]
                    && (state_r == pmw_pkg::PMW_ST_RUN);
  // Clear is a no-op when the watchdog is off [RULE16]
  assign clr_cmd = wr_en && (paddr == pmw_pkg::ADDR_COMMAND) && pwdata[pmw_pkg::CMD_CLRWDT_BIT]
                   && wdt_active;
  // On by configuration, or by any key other than the disable value [RULE17]
  assign wdt_active = cfg.wdt_on || (key_r != pmw_pkg::KEY_DISABLE);

  // Control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lowpwr_r <= 1'b0; // Quick start after power-on [RULE21]
      slow_sel_r <= 1'b0;
      key_r <= pmw_pkg::KEY_DISABLE; // [RULE18]
      tsel_r <= pmw_pkg::TSEL_RESET; // [RULE22]
      wake_mask_r <= pmw_pkg::WAKE_MASK_RESET;
    end else if (wr_en) begin
      case (paddr)
        pmw_pkg::ADDR_CLOCK_CTRL: begin
          lowpwr_r <= pwdata[pmw_pkg::CC_LOWPWR_BIT];
          slow_sel_r <= pwdata[pmw_pkg::CC_SLOW_BIT];
        end
        pmw_pkg::ADDR_WDT_CTRL: key_r <= pwdata[3:0];
        pmw_pkg::ADDR_WDT_SCALE: tsel_r <= pwdata[2:0]; // [RULE20]
        pmw_pkg::ADDR_WAKE_MASK: wake_mask_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // APB answer: zero wait, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel && !penable) begin
        case (paddr)
          pmw_pkg::ADDR_CLOCK_CTRL: prdata <= {30'h0, slow_sel_r, lowpwr_r};
          pmw_pkg::ADDR_WDT_CTRL: prdata <= {28'h0, key_r};
          pmw_pkg::ADDR_WDT_SCALE: prdata <= {29'h0, tsel_r};
          pmw_pkg::ADDR_WAKE_MASK: prdata <= {24'h0, wake_mask_r};
          pmw_pkg::ADDR_STATUS: prdata <= {24'h0, state_r, 2'h0, to_r, pdf_r};
          pmw_pkg::ADDR_COMMAND: prdata <= 32'h0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  logic unused_rd; // Reads carry no side effect
  assign unused_rd = rd_en;

  // ------------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------------
  logic [1:0] div4_r; // System clock divide by four
  logic [14:0] wdt_cnt_r; // Watchdog counter
  logic wdt_tick, wdt_ovf; // Count enable and overflow
  logic sleeping; // Sleep state
  assign sleeping = (state_r == pmw_pkg::PMW_ST_SLEEP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div4_r <= 2'h0;
    else div4_r <= div4_r + 2'h1;
  end

  // Source select; the divided system clock stops in sleep [RULE19] [RULE7]
  always_comb begin
    case (cfg.wdt_clk)
      pmw_pkg::PMW_WCK_SYS4: wdt_tick = (div4_r == pmw_pkg::SYNC_DIV4) && !sleeping;
      pmw_pkg::PMW_WCK_SLOW_INTERNAL_OSC: wdt_tick = slow_edge && cfg.slow_internal_osc_on;
      default: wdt_tick = slow_edge && is_rc_xtal(cfg.osc);
    endcase
  end

  // Period 2^(8+sel) ticks [RULE22]
  assign wdt_ovf = wdt_tick && (wdt_cnt_r == 15'((32'h1 << (pmw_pkg::WDT_BASE_LOG + 32'(tsel_r))) - 32'h1));

  // Counter cleared on halt, clear instruction, reset or overflow [RULE7]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wdt_cnt_r <= 15'h0;
    else if (halt_cmd || clr_cmd || !wdt_active || ext_rst_lvl || wdt_ovf) wdt_cnt_r <= 15'h0;
    else if (wdt_tick) wdt_cnt_r <= wdt_cnt_r + 15'h1;
  end

  // ------------------------------------------------------------------
  // Wake detection
  // ------------------------------------------------------------------
  logic port_wake, int_wake; // Wake sources
  // Falling edge on an enabled pin [RULE12]
  assign port_wake = |(pa_prev_r & ~pa_s2_r & wake_mask_r);
  // Requests pending before sleep never wake [RULE14]
  assign int_wake = int_request && !int_pending_before;

  logic [24:0] dly_r; // Startup delay counter
  logic int_woke_r; // Wake came from an interrupt

  // Mode sequencer [RULE9] [RULE15]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= pmw_pkg::PMW_ST_RESET_DLY;
      dly_r <= 25'h0;
      int_woke_r <= 1'b0;
    end else begin
      case (state_r)
        pmw_pkg::PMW_ST_RUN: begin
          if (ext_rst_lvl || wdt_ovf) begin
            state_r <= pmw_pkg::PMW_ST_RESET_DLY;
            dly_r <= 25'h0;
          end else if (halt_cmd) begin
            state_r <= pmw_pkg::PMW_ST_SLEEP; // [RULE5] [RULE6]
          end
        end
        pmw_pkg::PMW_ST_SLEEP: begin
          dly_r <= 25'h0;
          if (ext_rst_lvl) begin
            state_r <= pmw_pkg::PMW_ST_RESET_DLY;
          end else if (wdt_ovf || port_wake || int_wake) begin
            state_r <= pmw_pkg::PMW_ST_START_DLY;
            int_woke_r <= int_wake && !wdt_ovf;
          end
        end
        pmw_pkg::PMW_ST_RESET_DLY: begin
          // Reset delay, then long startup [RULE15]
          if (ext_rst_lvl) dly_r <= 25'h0;
          else if (dly_r == 25'(RESET_DELAY_CYCLES + 32'(pmw_pkg::LONG_STARTUP_CYC) - 1)) begin
            state_r <= pmw_pkg::PMW_ST_RUN;
            int_woke_r <= 1'b0;
          end else dly_r <= dly_r + 25'h1;
        end
        pmw_pkg::PMW_ST_START_DLY: begin
          if (ext_rst_lvl) begin
            state_r <= pmw_pkg::PMW_ST_RESET_DLY;
            dly_r <= 25'h0;
          end else if (dly_r == 25'((is_rc(cfg.osc) ? pmw_pkg::SHORT_STARTUP_CYC
                                                    : pmw_pkg::LONG_STARTUP_CYC) - 8'h1)) begin
            state_r <= pmw_pkg::PMW_ST_RUN;
          end else dly_r <= dly_r + 25'h1;
        end
        default: state_r <= pmw_pkg::PMW_ST_RESET_DLY;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------------
  // Power-up clears both; halt sets power-down and clears expired [RULE8] [RULE11]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdf_r <= 1'b0;
      to_r <= 1'b0;
    end else if (halt_cmd) begin
      pdf_r <= 1'b1;
      to_r <= 1'b0;
    end else if (wdt_ovf) begin
      to_r <= 1'b1; // [RULE10]
    end else if (clr_cmd) begin
      pdf_r <= 1'b0;
      to_r <= 1'b0;
    end else if (ext_rst_lvl) begin
      pdf_r <= 1'b0;
      to_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Outputs to core and oscillators
  // ------------------------------------------------------------------
  logic slow_req; // Slow clock requested and legal [RULE3]
  assign slow_req = slow_sel_r && is_rc_xtal(cfg.osc);

  // Core control pulses and levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_run <= 1'b0;
      core_hold <= 1'b0;
      full_reset <= 1'b1;
      pc_sp_reset <= 1'b0;
      int_service <= 1'b0;
    end else begin
      core_run <= (state_r == pmw_pkg::PMW_ST_RUN) && !halt_cmd;
      core_hold <= sleeping || halt_cmd; // [RULE6]
      full_reset <= (state_r == pmw_pkg::PMW_ST_RESET_DLY) || ext_rst_lvl; // [RULE10]
      // Watchdog reset: overflow in sleep resets PC and stack only [RULE10] [RULE16]
      pc_sp_reset <= wdt_ovf && (state_r == pmw_pkg::PMW_ST_RUN || sleeping);
      // Service only if enabled and stack free, else stays pending [RULE13]
      int_service <= (state_r == pmw_pkg::PMW_ST_START_DLY) && int_woke_r && int_enabled
                     && !stack_full && (dly_r == 25'h0);
    end
  end

  // Oscillator control; clock change only at a divide-by-4 boundary on a slow edge [RULE23]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_ctl <= '0;
    end else begin
      // Fast oscillator stops in sleep whatever slow select says [RULE5]
      osc_ctl.fast_osc_en <= !sleeping && !halt_cmd && !(slow_req && osc_ctl.sys_clk_slow);
      // Crystal runs always in RC+crystal config [RULE4] [RULE2]
      osc_ctl.slow_crystal_en <= is_rc_xtal(cfg.osc);
      osc_ctl.slow_rc_en <= cfg.slow_internal_osc_on; // [RULE1]
      osc_ctl.crystal_low_power <= lowpwr_r; // [RULE2]
      // Switch source at a divide boundary so no short pulse reaches the core [RULE23]
      if (div4_r == pmw_pkg::SYNC_DIV4 && slow_edge) osc_ctl.sys_clk_slow <= slow_req;
    end
  end

endmodule

/* File: pmw_sva.sv */
// Port-level checker for the power mode, wake-up and watchdog block
`timescale 1ns/100ps
module pmw_sva #(
  parameter int RESET_DELAY_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire pmw_pkg::pmw_cfg_t cfg,
  input wire logic ext_reset_n,
  input wire pmw_pkg::pmw_osc_ctl_t osc_ctl,
  input wire logic core_run,
  input wire logic core_hold,
  input wire logic full_reset,
  input wire logic pc_sp_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles spent in reset delay since reset was let go
  int dly_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dly_r <= 0;
    else if (!full_reset || !ext_reset_n)
      dly_r <= 0;
    else
      dly_r <= dly_r + 1;
  end
  // Halt strobe accepted while running
  sequence s_halt_write;
    psel && penable && pwrite && paddr == pmw_pkg::ADDR_COMMAND && pwdata[0] && core_run;
  endsequence
  a_halt_enters_sleep: assert property (s_halt_write |-> ##[1:3] core_hold)
    else $error("halt did not enter sleep");
  a_sleep_fast_off: assert property (core_hold && $past(core_hold) |-> !osc_ctl.fast_osc_en)
    else $error("fast oscillator runs in sleep");
  a_sleep_no_run: assert property (core_hold |-> !core_run)
    else $error("core runs in sleep");
  a_xtal_sleep_on: assert property (core_hold && cfg.osc == 3'h3 |-> osc_ctl.slow_crystal_en)
    else $error("slow crystal stopped");
  a_slow_needs_cfg: assert property (cfg.osc != 3'h3 && $stable(cfg) |-> !osc_ctl.sys_clk_slow)
    else $error("slow clock outside combined config");
  a_slow_internal_osc_in_sleep: assert property (core_hold && $past(core_hold) |-> osc_ctl.slow_rc_en == cfg.slow_internal_osc_on)
    else $error("slow rc enable wrong in sleep");
  a_ext_reset_full: assert property ($fell(ext_reset_n) |-> ##[1:4] full_reset)
    else $error("external reset not full");
  a_wdt_pulse_one: assert property (pc_sp_reset |=> !pc_sp_reset)
    else $error("counter reset pulse too long");
  a_reset_delay_min: assert property ($fell(full_reset) |-> dly_r >= RESET_DELAY_CYCLES + 126)
    else $error("reset delay too short");
  a_reset_delay_max: assert property (dly_r <= RESET_DELAY_CYCLES + 131)
    else $error("reset delay too long");
endmodule

bind pmw_top pmw_sva #(.RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .cfg(cfg), .ext_reset_n(ext_reset_n), .osc_ctl(osc_ctl),
  .core_run(core_run), .core_hold(core_hold), .full_reset(full_reset), .pc_sp_reset(pc_sp_reset)
);

/* File: test_pmw_top.sv */
// Self-checking bench for the power mode, wake-up and watchdog block
`timescale 1ns/100ps
module test_pmw_top;
  localparam int RDLY = 20; // Short reset delay for simulation
  logic pclk, presetn, psel, penable, pwrite, ext_reset_n, int_request, int_enabled, stack_full, int_pending_before;
  logic slow_tick = 1'b0; // Slow oscillator, period 8 cycles
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, core_run, core_hold, full_reset, pc_sp_reset, int_service;
  logic [7:0] port_a_pins;
  pmw_pkg::pmw_cfg_t cfg;
  pmw_pkg::pmw_osc_ctl_t osc_ctl;
  int num_errors = 0, tests_run = 0, cyc = 0, svc = 0, seed, k, n;

  pmw_top #(.RESET_DELAY_CYCLES(RDLY)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg),
    .ext_reset_n(ext_reset_n), .port_a_pins(port_a_pins), .slow_tick(slow_tick), .int_request(int_request),
    .int_enabled(int_enabled), .stack_full(stack_full), .int_pending_before(int_pending_before),
    .osc_ctl(osc_ctl), .core_run(core_run), .core_hold(core_hold), .full_reset(full_reset),
    .pc_sp_reset(pc_sp_reset), .int_service(int_service)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Slow tick, service pulse count and run limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    slow_tick <= cyc[2];
    if (int_service === 1'b1)
      svc <= svc + 1;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; result left in rd and er
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer settles mid-cycle and stands up to the sampling edge
    @(negedge pclk);
    while (pready !== 1'b1 && t < 20) begin
      @(negedge pclk);
      t++;
    end
    if (t == 20)
      num_errors++;
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so a following call never reassigns psel in one step
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  // Wait for sleep (hold=1) or run (hold=0), n left as cycles taken
  task automatic wait_mode(input logic hold, input int lim);
    n = 0;
    while (!(hold ? core_hold === 1'b1 : core_run === 1'b1) && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check(32'(n < lim), 32'h1);
  endtask

  task automatic halt();
    apb(1'b1, pmw_pkg::ADDR_COMMAND, 32'h1);
    wait_mode(1'b1, 10);
    check({31'h0, core_hold & ~core_run}, 32'h1);
  endtask

  initial begin
    seed = 32'hd34f9707;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_reset_n = 1'b1;
    port_a_pins = 8'hff;
    int_request = 1'b0;
    int_enabled = 1'b0;
    stack_full = 1'b0;
    int_pending_before = 1'b0;
    cfg = '{osc: 3'h2, wdt_clk: 2'h2, wdt_on: 1'b0, slow_internal_osc_on: 1'b1};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wait_mode(1'b0, 400);
    // ----------------------------------------
    // Reset values and random scale
    // ----------------------------------------
    rdc(pmw_pkg::ADDR_WDT_CTRL, 32'ha);
    rdc(pmw_pkg::ADDR_WDT_SCALE, 32'h7);
    rdc(pmw_pkg::ADDR_CLOCK_CTRL, 32'h0);
    rdc(pmw_pkg::ADDR_WAKE_MASK, 32'h0);
    rdc(pmw_pkg::ADDR_STATUS, 32'h10);
    apb(1'b0, 12'h0f0, 32'h0);
    check({31'h0, er}, 32'h1);
    k = $unsigned($random(seed)) % 8;
    apb(1'b1, pmw_pkg::ADDR_WDT_SCALE, k);
    rdc(pmw_pkg::ADDR_WDT_SCALE, k);
    $display("test reset values done");
    // ----------------------------------------
    // Port wake, masked and unmasked pins
    // ----------------------------------------
    apb(1'b1, pmw_pkg::ADDR_WAKE_MASK, 32'h1 << k);
    halt();
    rdc(pmw_pkg::ADDR_STATUS, 32'h21);
    check(osc_ctl.fast_osc_en, 1'b0);
    port_a_pins <= ~(8'h1 << ((k + 1) % 8));
    repeat (10) @(posedge pclk);
    check(core_hold, 1'b1);
    port_a_pins <= 8'hff;
    @(posedge pclk);
    port_a_pins <= ~(8'h1 << k);
    wait_mode(1'b0, 12);
    port_a_pins <= 8'hff;
    $display("test port wake done");
    // ----------------------------------------
    // Interrupt wake: blocked, disabled, served, stack full
    // ----------------------------------------
    for (int i = 0; i < 3; i++) begin
      int_enabled <= (i > 0);
      stack_full <= (i == 2);
      int_pending_before <= 1'b1;
      halt();
      int_request <= 1'b1;
      repeat (10) @(posedge pclk);
      check(core_hold, 1'b1);
      k = svc;
      int_pending_before <= 1'b0;
      wait_mode(1'b0, 12);
      @(posedge pclk);
      check(svc - k, 32'(i == 1));
      int_request <= 1'b0;
    end
    $display("test interrupt wake done");
    // ----------------------------------------
    // Watchdog overflow in sleep, then disabled
    // ----------------------------------------
    apb(1'b1, pmw_pkg::ADDR_WDT_CTRL, 32'h5);
    apb(1'b1, pmw_pkg::ADDR_WDT_SCALE, 32'h0);
    apb(1'b1, pmw_pkg::ADDR_COMMAND, 32'h2);
    rdc(pmw_pkg::ADDR_STATUS, 32'h10);
    halt();
    k = cyc;
    n = 0;
    while (pc_sp_reset !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    check(32'((cyc - k) >= 2030 && (cyc - k) <= 2070), 32'h1);
    wait_mode(1'b0, 20);
    check(full_reset, 1'b0);
    rdc(pmw_pkg::ADDR_STATUS, 32'h13);
    apb(1'b1, pmw_pkg::ADDR_WDT_CTRL, 32'ha);
    apb(1'b1, pmw_pkg::ADDR_COMMAND, 32'h2);
    rdc(pmw_pkg::ADDR_STATUS, 32'h13);
    $display("test watchdog done");
    // ----------------------------------------
    // External reset, then combined oscillator config
    // ----------------------------------------
    ext_reset_n <= 1'b0;
    repeat (5) @(posedge pclk);
    check(full_reset, 1'b1);
    ext_reset_n <= 1'b1;
    wait_mode(1'b0, 400);
    rdc(pmw_pkg::ADDR_WDT_SCALE, 32'h0);
    cfg.osc <= 3'h3;
    repeat (4) @(posedge pclk);
    check(osc_ctl.slow_crystal_en, 1'b1);
    apb(1'b1, pmw_pkg::ADDR_CLOCK_CTRL, 32'h3);
    rdc(pmw_pkg::ADDR_CLOCK_CTRL, 32'h3);
    n = 0;
    while (osc_ctl.sys_clk_slow !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    check(osc_ctl.sys_clk_slow, 1'b1);
    check(osc_ctl.slow_crystal_en & osc_ctl.crystal_low_power, 1'b1);
    apb(1'b1, pmw_pkg::ADDR_WAKE_MASK, 32'h1);
    halt();
    check(osc_ctl.slow_crystal_en, 1'b1);
    port_a_pins <= 8'hfe;
    wait_mode(1'b0, 200);
    port_a_pins <= 8'hff;
    $display("test reset and slow clock done");
    conclude();
  end
endmodule
